// ### rtl/pmwrd_top.sv
// planar memory write/read datapath with video load fifo
// assumes map read data valid in the cycle of a host read strobe
//
// Function
// - index port selects register for data port
// - mode 0 enabled maps filled, then masked
// - mode 0 disabled maps get rotated host byte
// - mode bits 1:0 choose write mode
// - compare read: one where all maps enabled by the don't-care register match
// - read type zero returns raw map data
// - function select: pass, and, or, xor
// - three-bit right rotate of host byte
// - map select picks direct read source
// - odd/even: select picks chained map pair
// - read type one returns compare result when chain mode is off
// - chain mode overrides direct read setting
// - four-bit pixel, top outputs from colour select
// - 256-colour bit selects byte-wide pixel loading
// - plain load maps to registers, msb first
// - shift bit: even/odd bits split
// - odd/even: address bit zero picks maps
// - bit mask keeps latched bits at zero
// - reads load latches; mode 1 writes latches
// - mode 2 fills map from host bit
// - mode 3 fill, rotated data masks
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
module pmwrd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    nxt_wp;
  logic [AW-1:0]    rp_ff;
  logic [AW-1:0]    nxt_rp;
  logic [CW-1:0]    cnt_ff;
  logic [CW-1:0]    nxt_cnt;
  logic             push;
  logic             pop;
  logic             rdy_ff;
  logic             nxt_rdy;

  always_comb
  begin
    push    = clk_en_i && in_valid_i && (cnt_ff != FULL_CNT);
    pop     = clk_en_i && out_ready_i && (cnt_ff != '0);
    nxt_wp  = push ? ((wp_ff == LAST_PTR) ? '0 : wp_ff + AW'(1)) : wp_ff;
    nxt_rp  = pop ? ((rp_ff == LAST_PTR) ? '0 : rp_ff + AW'(1)) : rp_ff;
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
    nxt_rdy = (nxt_cnt != FULL_CNT);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end
    else
    begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  // storage holds no control state, so no reset
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end

  assign in_ready_o  = rdy_ff;
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rp_ff];
endmodule : pmwrd_fifo

////////////////////////////////////////////////////////////////////////
module pmwrd_top #(
  parameter int VW = pmwrd_pkg::VID_W,
  parameter int VD = pmwrd_pkg::VID_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_data_sel_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  input  wire logic        mem_wr_i,
  input  wire logic        mem_rd_i,
  input  wire logic [1:0]  mem_addr_i,
  input  wire logic [7:0]  host_data_i,
  input  wire logic [31:0] map_rdata_i,
  input  wire logic        seq_chain_i,
  output logic      [31:0] map_wdata_o,
  output logic      [3:0]  map_we_o,
  output logic             map_wvalid_o,
  output logic      [7:0]  mem_rdata_o,
  output logic             mem_rvalid_o,
  input  wire logic        vid_valid_i,
  input  wire logic [VW-1:0] vid_data_i,
  output logic             vid_ready_o,
  input  wire logic        dot_en_i,
  input  wire logic [1:0]  colour_sel_i,
  output logic      [3:0]  pixel_o,
  output logic             upper_video_out_a_o,
  output logic             upper_video_out_b_o
);
  logic [3:0]  fill_value_ff;
  logic [3:0]  nxt_fill_value;
  logic [3:0]  fill_enable_ff;
  logic [3:0]  nxt_fill_enable;
  logic [3:0]  compare_value_ff;
  logic [3:0]  nxt_compare_value;
  logic [4:0]  rotate_op_ff;
  logic [4:0]  nxt_rotate_op;
  logic [1:0]  read_plane_ff;
  logic [1:0]  nxt_read_plane;
  logic [7:0]  mode_ctrl_ff;
  logic [7:0]  nxt_mode_ctrl;
  logic [3:0]  dont_care_ff;
  logic [3:0]  nxt_dont_care;
  logic [7:0]  bit_mask_ff;
  logic [7:0]  nxt_bit_mask;
  logic [3:0]  reg_ptr_ff;
  logic [3:0]  nxt_reg_ptr;
  logic [31:0] latch_ff;
  logic [31:0] nxt_latch;
  logic [7:0]  io_rdata_ff;
  logic [7:0]  nxt_io_rdata;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [3:0]  we_ff;
  logic [3:0]  nxt_we;
  logic        wvalid_ff;
  logic        nxt_wvalid;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [7:0]  rot_byte;
  logic [7:0]  cmp_byte;
  logic [1:0]  rd_map;
  logic [1:0]  wmode;

  function automatic logic [7:0] ror8(input logic [7:0] x, input logic [2:0] n);
    logic [15:0] t;
    t = {x, x} >> n;
    return t[7:0];
  endfunction : ror8

  //////////////////////////////////////////////////////////////////////
  // register port and host datapath
  always_comb
  begin
    nxt_fill_value    = fill_value_ff;
    nxt_fill_enable   = fill_enable_ff;
    nxt_compare_value = compare_value_ff;
    nxt_rotate_op     = rotate_op_ff;
    nxt_read_plane    = read_plane_ff;
    nxt_mode_ctrl     = mode_ctrl_ff;
    nxt_dont_care     = dont_care_ff;
    nxt_bit_mask      = bit_mask_ff;
    nxt_reg_ptr       = reg_ptr_ff;
    nxt_latch         = latch_ff;
    nxt_io_rdata      = io_rdata_ff;
    nxt_wdata         = wdata_ff;
    nxt_we            = we_ff;
    nxt_rdata         = rdata_ff;
    nxt_wvalid        = 1'b0;
    nxt_rvalid        = 1'b0;
    wmode    = mode_ctrl_ff[1:0];
    rot_byte = ror8(host_data_i, rotate_op_ff[2:0]);
    cmp_byte = 8'hFF;
    for (int i = 0; i < 4; i++)
    begin
      cmp_byte = cmp_byte & ~((map_rdata_i[8*i +: 8] ^ {8{compare_value_ff[i]}})
                 & {8{dont_care_ff[i]}});
    end
    rd_map = read_plane_ff;
    if (seq_chain_i)
    begin
      rd_map = mem_addr_i;
    end
    else if (mode_ctrl_ff[pmwrd_pkg::MODE_OE_BIT])
    begin
      rd_map = {read_plane_ff[1], mem_addr_i[0]};
    end
    if (io_wr_i && !io_data_sel_i)
    begin
      nxt_reg_ptr = io_wdata_i[3:0];
    end
    if (io_wr_i && io_data_sel_i)
    begin
      case (reg_ptr_ff)
        pmwrd_pkg::IDX_FILL_VALUE:  nxt_fill_value    = io_wdata_i[3:0];
        pmwrd_pkg::IDX_FILL_ENABLE: nxt_fill_enable   = io_wdata_i[3:0];
        pmwrd_pkg::IDX_COMPARE:     nxt_compare_value = io_wdata_i[3:0];
        pmwrd_pkg::IDX_ROTATE_OP:   nxt_rotate_op     = io_wdata_i[4:0];
        pmwrd_pkg::IDX_READ_PLANE:  nxt_read_plane    = io_wdata_i[1:0];
        pmwrd_pkg::IDX_MODE_CTRL:   nxt_mode_ctrl     = io_wdata_i & pmwrd_pkg::MODE_RW_MASK;
        pmwrd_pkg::IDX_DONT_CARE:   nxt_dont_care     = io_wdata_i[3:0];
        pmwrd_pkg::IDX_BIT_MASK:    nxt_bit_mask      = io_wdata_i;
        default:                    nxt_reg_ptr       = reg_ptr_ff;
      endcase
    end
    if (io_rd_i)
    begin
      case (io_data_sel_i ? reg_ptr_ff : 4'hF)
        pmwrd_pkg::IDX_FILL_VALUE:  nxt_io_rdata = {4'h0, fill_value_ff};
        pmwrd_pkg::IDX_FILL_ENABLE: nxt_io_rdata = {4'h0, fill_enable_ff};
        pmwrd_pkg::IDX_COMPARE:     nxt_io_rdata = {4'h0, compare_value_ff};
        pmwrd_pkg::IDX_ROTATE_OP:   nxt_io_rdata = {3'h0, rotate_op_ff};
        pmwrd_pkg::IDX_READ_PLANE:  nxt_io_rdata = {6'h00, read_plane_ff};
        pmwrd_pkg::IDX_MODE_CTRL:   nxt_io_rdata = mode_ctrl_ff;
        pmwrd_pkg::IDX_DONT_CARE:   nxt_io_rdata = {4'h0, dont_care_ff};
        pmwrd_pkg::IDX_BIT_MASK:    nxt_io_rdata = bit_mask_ff;
        default:                    nxt_io_rdata = io_data_sel_i ? 8'h00 : {4'h0, reg_ptr_ff};
      endcase
    end
    if (mem_rd_i)
    begin
      nxt_latch  = map_rdata_i;
      nxt_rvalid = 1'b1;
      // compare result when read type set and chain off
      if (!seq_chain_i && mode_ctrl_ff[pmwrd_pkg::MODE_RT_BIT])
      begin
        nxt_rdata = cmp_byte;
      end
      else
      begin
        nxt_rdata = map_rdata_i[8*rd_map +: 8];
      end
    end
    if (mem_wr_i)
    begin
      nxt_wvalid = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        logic [7:0] src;
        logic [7:0] msk;
        logic [7:0] alu;
        logic [7:0] lat;
        alu = 8'h00;
        lat = latch_ff[8*i +: 8];
        src = rot_byte;
        msk = bit_mask_ff;
        case (wmode)
          pmwrd_pkg::WM0: src = fill_enable_ff[i] ? {8{fill_value_ff[i]}} : rot_byte;
          pmwrd_pkg::WM2: src = {8{host_data_i[i]}};
          pmwrd_pkg::WM3:
          begin
            src = {8{fill_value_ff[i]}};
            msk = rot_byte & bit_mask_ff;
          end
          default: src = rot_byte;
        endcase
        case (rotate_op_ff[4:pmwrd_pkg::ROT_OP_LSB])
          pmwrd_pkg::LOP_AND: alu = src & lat;
          pmwrd_pkg::LOP_OR:  alu = src | lat;
          pmwrd_pkg::LOP_XOR: alu = src ^ lat;
          default:            alu = src;
        endcase
        nxt_wdata[8*i +: 8] = (wmode == pmwrd_pkg::WM1) ? lat : ((alu & msk) | (lat & ~msk));
      end
      nxt_we = pmwrd_pkg::WE_ALL;
      if (mode_ctrl_ff[pmwrd_pkg::MODE_OE_BIT])
      begin
        nxt_we = mem_addr_i[0] ? pmwrd_pkg::WE_ODD : pmwrd_pkg::WE_EVEN;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fill_value_ff    <= pmwrd_pkg::RST_NIB;
      fill_enable_ff   <= pmwrd_pkg::RST_NIB;
      compare_value_ff <= pmwrd_pkg::RST_NIB;
      rotate_op_ff     <= '0;
      read_plane_ff    <= '0;
      mode_ctrl_ff     <= pmwrd_pkg::RST_BYTE;
      dont_care_ff     <= pmwrd_pkg::RST_NIB;
      bit_mask_ff      <= pmwrd_pkg::RST_MASK;
      reg_ptr_ff       <= pmwrd_pkg::RST_NIB;
      latch_ff         <= pmwrd_pkg::RST_WORD;
      io_rdata_ff      <= pmwrd_pkg::RST_BYTE;
      wdata_ff         <= pmwrd_pkg::RST_WORD;
      we_ff            <= pmwrd_pkg::RST_NIB;
      wvalid_ff        <= 1'b0;
      rdata_ff         <= pmwrd_pkg::RST_BYTE;
      rvalid_ff        <= 1'b0;
    end
    else if (clk_en_i)
    begin
      fill_value_ff    <= nxt_fill_value;
      fill_enable_ff   <= nxt_fill_enable;
      compare_value_ff <= nxt_compare_value;
      rotate_op_ff     <= nxt_rotate_op;
      read_plane_ff    <= nxt_read_plane;
      mode_ctrl_ff     <= nxt_mode_ctrl;
      dont_care_ff     <= nxt_dont_care;
      bit_mask_ff      <= nxt_bit_mask;
      reg_ptr_ff       <= nxt_reg_ptr;
      latch_ff         <= nxt_latch;
      io_rdata_ff      <= nxt_io_rdata;
      wdata_ff         <= nxt_wdata;
      we_ff            <= nxt_we;
      wvalid_ff        <= nxt_wvalid;
      rdata_ff         <= nxt_rdata;
      rvalid_ff        <= nxt_rvalid;
    end
  end

  assign io_rdata_o   = io_rdata_ff;
  assign map_wdata_o  = wdata_ff;
  assign map_we_o     = we_ff;
  assign map_wvalid_o = wvalid_ff;
  assign mem_rdata_o  = rdata_ff;
  assign mem_rvalid_o = rvalid_ff;

  //////////////////////////////////////////////////////////////////////
  // video load path
  logic          fifo_valid;
  logic [VW-1:0] fifo_data;
  logic          fifo_pop;
  logic [31:0]   vsh_ff;
  logic [31:0]   nxt_vsh;
  logic [2:0]    vcnt_ff;
  logic [2:0]    nxt_vcnt;
  logic          vhave_ff;
  logic          nxt_vhave;
  logic [3:0]    pix_ff;
  logic [3:0]    nxt_pix;
  logic [1:0]    upper_ff;
  logic [1:0]    nxt_upper;

  // nibble k leaves on dot k, most significant first
  function automatic logic [31:0] vid_arrange(input logic [31:0] m, input logic sh, input logic c256);
    logic [31:0] w;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [7:0]  b;
    int          j;
    w = '0;
    for (int k = 0; k < 8; k++)
    begin
      j = k % 4;
      c = (k < 4) ? m[7:0] : m[15:8];
      d = (k < 4) ? m[23:16] : m[31:24];
      b = m[8*(k/2) +: 8];
      if (c256)
        w[31-4*k -: 4] = (k % 2 == 0) ? b[7:4] : b[3:0];
      else if (sh)
        w[31-4*k -: 4] = {d[7-2*j], d[6-2*j], c[7-2*j], c[6-2*j]};
      else
        w[31-4*k -: 4] = {m[31-k], m[23-k], m[15-k], m[7-k]};
    end
    return w;
  endfunction : vid_arrange

  pmwrd_fifo #(
    .WIDTH (VW),
    .DEPTH (VD)
  ) u_vfifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (vid_valid_i),
    .in_data_i   (vid_data_i),
    .in_ready_o  (vid_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  always_comb
  begin
    nxt_vsh   = vsh_ff;
    nxt_vcnt  = vcnt_ff;
    nxt_vhave = vhave_ff;
    nxt_pix   = pix_ff;
    nxt_upper = upper_ff;
    fifo_pop  = 1'b0;
    if (dot_en_i)
    begin
      nxt_pix   = vhave_ff ? vsh_ff[31:28] : 4'h0;
      nxt_upper = colour_sel_i;
      nxt_vsh   = {vsh_ff[27:0], 4'h0};
      nxt_vcnt  = vcnt_ff + 3'h1;
      if (vcnt_ff == pmwrd_pkg::LAST_NIB)
      begin
        nxt_vhave = 1'b0;
      end
      if ((!vhave_ff || vcnt_ff == pmwrd_pkg::LAST_NIB) && fifo_valid)
      begin
        fifo_pop  = 1'b1;
        nxt_vsh   = vid_arrange(fifo_data[31:0], mode_ctrl_ff[pmwrd_pkg::MODE_SH_BIT],
                                mode_ctrl_ff[pmwrd_pkg::MODE_256_BIT]);
        nxt_vcnt  = '0;
        nxt_vhave = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vsh_ff   <= pmwrd_pkg::RST_WORD;
      vcnt_ff  <= '0;
      vhave_ff <= 1'b0;
      pix_ff   <= pmwrd_pkg::RST_NIB;
      upper_ff <= '0;
    end
    else if (clk_en_i)
    begin
      vsh_ff   <= nxt_vsh;
      vcnt_ff  <= nxt_vcnt;
      vhave_ff <= nxt_vhave;
      pix_ff   <= nxt_pix;
      upper_ff <= nxt_upper;
    end
  end

  assign pixel_o             = pix_ff;
  assign upper_video_out_a_o = upper_ff[0];
  assign upper_video_out_b_o = upper_ff[1];

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  idx_load_a: assert property (clk_en_i && io_wr_i && !io_data_sel_i |=>
    reg_ptr_ff == $past(io_wdata_i[3:0])) else $error("index not loaded");
  fill_m0_a: assert property (clk_en_i && mem_wr_i && wmode == 2'h0 && fill_enable_ff[0]
    && rotate_op_ff[4:3] == 2'h0 |=> wdata_ff[7:0] == (({8{$past(fill_value_ff[0])}}
    & $past(bit_mask_ff)) | ($past(latch_ff[7:0]) & ~$past(bit_mask_ff))))
    else $error("fill mode 0 wrong");
  rot_m0_a: assert property (clk_en_i && mem_wr_i && wmode == 2'h0 && !fill_enable_ff[0]
    && rotate_op_ff == 5'h01 && bit_mask_ff == 8'hFF |=>
    wdata_ff[7:0] == {$past(host_data_i[0]), $past(host_data_i[7:1])}) else $error("rotate wrong");
  latch_copy_a: assert property (clk_en_i && mem_rd_i ##1 !mem_rd_i ##1 clk_en_i && mem_wr_i
    && wmode == 2'h1 |=> wdata_ff == $past(map_rdata_i, 3)) else $error("latch copy wrong");
  mask_keep_a: assert property (clk_en_i && mem_wr_i && bit_mask_ff == 8'h00
    && wmode != 2'h3 |=> wdata_ff == $past(latch_ff)) else $error("mask did not hold");
  cmp_read_a: assert property (clk_en_i && mem_rd_i && !seq_chain_i && mode_ctrl_ff[3]
    && dont_care_ff == 4'hF && compare_value_ff == 4'h0
    |=> rvalid_ff && rdata_ff == ~$past(map_rdata_i[7:0] | map_rdata_i[15:8] | map_rdata_i[23:16]
    | map_rdata_i[31:24])) else $error("compare read wrong");
  direct_rd_a: assert property (clk_en_i && mem_rd_i && !seq_chain_i && mode_ctrl_ff[4:3] == 2'h0
    && read_plane_ff == 2'h2 |=> rdata_ff == $past(map_rdata_i[23:16])) else $error("direct read wrong");
  chain_rd_a: assert property (clk_en_i && mem_rd_i && seq_chain_i
    |=> rdata_ff == $past(map_rdata_i[8*mem_addr_i +: 8])) else $error("chain read wrong");
  odd_even_a: assert property (clk_en_i && mem_wr_i && mode_ctrl_ff[4] && mem_addr_i[0]
    |=> we_ff == 4'hA) else $error("odd/even enables wrong");

  wr_m3_c: cover property (clk_en_i && mem_wr_i && wmode == 2'h3);
  cmp_rd_c: cover property (clk_en_i && mem_rd_i && mode_ctrl_ff[3]);
  fifo_full_c: cover property (!vid_ready_o ##1 fifo_pop);
endmodule : pmwrd_top

// ### shared/pmwrd_pkg.sv
// constants of the planar memory write/read datapath
// assumes one clock; host accesses arrive as single-cycle strobes
package pmwrd_pkg;
  // graphics register indices behind the data port
  localparam logic [3:0] IDX_FILL_VALUE   = 4'h0;
  localparam logic [3:0] IDX_FILL_ENABLE  = 4'h1;
  localparam logic [3:0] IDX_COMPARE      = 4'h2;
  localparam logic [3:0] IDX_ROTATE_OP    = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE   = 4'h4;
  localparam logic [3:0] IDX_MODE_CTRL    = 4'h5;
  localparam logic [3:0] IDX_DONT_CARE    = 4'h7;
  localparam logic [3:0] IDX_BIT_MASK     = 4'h8;
  // field positions
  localparam int ROT_OP_LSB   = 3;
  localparam int MODE_RT_BIT  = 3;
  localparam int MODE_OE_BIT  = 4;
  localparam int MODE_SH_BIT  = 5;
  localparam int MODE_256_BIT = 6;
  // writable bits of the mode register (7 and 2 reserved)
  localparam logic [7:0] MODE_RW_MASK = 8'h7B;
  // write modes and logical functions
  localparam logic [1:0] WM0 = 2'h0;
  localparam logic [1:0] WM1 = 2'h1;
  localparam logic [1:0] WM2 = 2'h2;
  localparam logic [1:0] WM3 = 2'h3;
  localparam logic [1:0] LOP_PASS = 2'h0;
  localparam logic [1:0] LOP_AND  = 2'h1;
  localparam logic [1:0] LOP_OR   = 2'h2;
  localparam logic [1:0] LOP_XOR  = 2'h3;
  // reset values
  localparam logic [3:0] RST_NIB   = 4'h0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'hFF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // odd/even write enables
  localparam logic [3:0] WE_ALL  = 4'hF;
  localparam logic [3:0] WE_EVEN = 4'h5;
  localparam logic [3:0] WE_ODD  = 4'hA;
  // video word and fifo defaults
  localparam int VID_W      = 32;
  localparam int VID_DEPTH  = 16;
  localparam logic [2:0] LAST_NIB = 3'h7;
endpackage : pmwrd_pkg

// ### verif/pmwrd_mem_model.sv
// display memory model: four map bytes at each of four addresses
// assumes map writes arrive one cycle after the host strobe
`timescale 1ns/10ps
module pmwrd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [1:0]  addr_i,
  input  wire logic        wvalid_i,
  input  wire logic [3:0]  we_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem_q [4] = '{32'h1E5A_C30F, 32'h0FF0_33CC, 32'hA55A_9669, 32'h7E81_00FF};
  logic [1:0]  addr_ff = 2'h0;
  // bus released outside reads: show the inverse
  assign rdata_o = rd_i ? mem_q[addr_i] : ~mem_q[addr_i];
  always @(posedge clk_i)
  begin
    addr_ff <= addr_i;
    if (wvalid_i)
      for (int i = 0; i < 4; i++)
        if (we_i[i])
          mem_q[addr_ff][8*i +: 8] <= wdata_i[8*i +: 8];
  end
endmodule : pmwrd_mem_model

// ### verif/tb.sv
// self-checking bench of the planar datapath with memory model
// assumes clock enable held high throughout
`timescale 1ns/10ps
module tb;
  logic        clk_i = 0, sys_rst_i = 1, io_wr_i = 0, io_rd_i = 0, io_data_sel_i = 0;
  logic [7:0]  io_wdata_i = 0, host_data_i = 0, io_rdata_o, mem_rdata_o;
  logic        mem_wr_i = 0, mem_rd_i = 0, seq_chain_i = 0, vid_valid_i = 0, dot_en_i = 0;
  logic [1:0]  mem_addr_i = 0, colour_sel_i = 0;
  logic [31:0] vid_data_i = 0, map_rdata_i, map_wdata_o;
  logic [3:0]  map_we_o, pixel_o;
  logic        map_wvalid_o, mem_rvalid_o, vid_ready_o, upper_video_out_a_o, upper_video_out_b_o;
  int          failures = 0;
  int          compares = 0;
  logic [31:0] seed = 32'h2CD5_1D08;
  logic [7:0]  rv [9];
  localparam logic [7:0] MSK [9] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h7B, 8'h00, 8'h0F, 8'hFF};
  // corner settings: plain rotate by one, then compare read against zero
  localparam logic [7:0] CRN [2][9] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF},
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h0F, 8'hFF}};

  pmwrd_top #(.VW(32), .VD(16)) dut (.clk_i, .sys_rst_i, .clk_en_i(1'b1), .io_wr_i, .io_rd_i,
    .io_data_sel_i, .io_wdata_i, .io_rdata_o, .mem_wr_i, .mem_rd_i, .mem_addr_i, .host_data_i,
    .map_rdata_i, .seq_chain_i, .map_wdata_o, .map_we_o, .map_wvalid_o, .mem_rdata_o, .mem_rvalid_o,
    .vid_valid_i, .vid_data_i, .vid_ready_o, .dot_en_i, .colour_sel_i, .pixel_o,
    .upper_video_out_a_o, .upper_video_out_b_o);
  pmwrd_mem_model mdl (.clk_i, .rd_i(mem_rd_i), .addr_i(mem_addr_i), .wvalid_i(map_wvalid_o),
    .we_i(map_we_o), .wdata_i(map_wdata_o), .rdata_o(map_rdata_i));

  initial forever #4 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [31:0] exp_wr(logic [7:0] h, logic [31:0] lat);
    logic [7:0]  r, d, l, m;
    logic [31:0] o;
    r = 8'({h, h} >> rv[3][2:0]);
    m = (rv[5][1:0] == 2'h3) ? (r & rv[8]) : rv[8];
    for (int i = 0; i < 4; i++)
    begin
      l = lat[8*i +: 8];
      case (rv[5][1:0])
        2'h0: d = rv[1][i] ? {8{rv[0][i]}} : r;
        2'h2: d = {8{h[i]}};
        default: d = {8{rv[0][i]}};
      endcase
      case (rv[3][4:3])
        2'h1: d = d & l;
        2'h2: d = d | l;
        2'h3: d = d ^ l;
        default: d = d;
      endcase
      o[8*i +: 8] = (rv[5][1:0] == 2'h1) ? l : ((d & m) | (l & ~m));
    end
    return o;
  endfunction : exp_wr

  function automatic logic [7:0] exp_rd(logic [31:0] mp, logic [1:0] a, logic ch);
    logic [7:0] o;
    logic [1:0] k;
    o = 8'hFF;
    k = rv[5][4] ? {rv[4][1], a[0]} : rv[4][1:0];
    if (ch)
      return mp[8*a +: 8];
    if (!rv[5][3])
      return mp[8*k +: 8];
    for (int i = 0; i < 4; i++)
      if (rv[7][i])
        o = o & ~(mp[8*i +: 8] ^ {8{rv[2][i]}});
    return o;
  endfunction : exp_rd

  function automatic logic [3:0] nib(logic [31:0] w, int k, logic [7:0] md);
    logic [7:0] c, e;
    int         j;
    j = k % 4;
    c = w[(k < 4 ? 0 : 8) +: 8];
    e = w[(k < 4 ? 16 : 24) +: 8];
    if (md[6])
      return w[4*(k ^ 1) +: 4];
    if (md[5])
      return {e[7-2*j], e[6-2*j], c[7-2*j], c[6-2*j]};
    return {w[31-k], w[23-k], w[15-k], w[7-k]};
  endfunction : nib

  ////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic io(logic wr, logic sel, logic [7:0] d);
    @(posedge clk_i);
    io_wr_i <= wr;
    io_rd_i <= ~wr;
    io_data_sel_i <= sel;
    io_wdata_i <= d;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    #1;
  endtask : io

  task automatic rreg(int idx, logic [7:0] e);
    io(1'b1, 1'b0, 8'(idx));
    io(1'b0, 1'b1, 8'h00);
    chk("register", e, io_rdata_o);
  endtask : rreg

  task automatic mem(logic wr, logic [1:0] a, logic [7:0] h);
    @(posedge clk_i);
    mem_wr_i <= wr;
    mem_rd_i <= ~wr;
    mem_addr_i <= a;
    host_data_i <= h;
    @(posedge clk_i);
    mem_wr_i <= 1'b0;
    mem_rd_i <= 1'b0;
    #1;
  endtask : mem

  task automatic vrun(logic [7:0] md, int n);
    logic [31:0] w [16];
    logic [3:0]  got [$];
    logic [1:0]  cs;
    logic        d, ok, hit;
    hit = 0;
    io(1'b1, 1'b0, 8'h05);
    io(1'b1, 1'b1, md);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      w[i] = rnd();
      vid_valid_i <= 1'b1;
      vid_data_i <= w[i];
    end
    // full fifo must refuse the extra word
    @(posedge clk_i);
    vid_valid_i <= (n == 16);
    vid_data_i <= 32'hFFFF_FFFF;
    #1 chk("fifo ready", 32'(n < 16), vid_ready_o);
    @(posedge clk_i);
    vid_valid_i <= 1'b0;
    for (int c = 0; c < 40 * n && got.size() < 8 * n + 6; c++)
    begin
      @(posedge clk_i);
      d = dot_en_i;
      cs = colour_sel_i;
      dot_en_i <= ^rnd() | seed[3];
      colour_sel_i <= seed[5:4];
      #1;
      if (d)
      begin
        got.push_back(pixel_o);
        chk("upper video", cs, {upper_video_out_b_o, upper_video_out_a_o});
      end
    end
    dot_en_i <= 1'b0;
    chk("dot wait", 1, 32'(got.size() >= 8 * n + 6));
    for (int off = 0; off < 4; off++)
    begin
      ok = 1;
      for (int k = 0; k < 8 * n; k++)
        if (got[off+k] !== nib(w[k/8], k % 8, md))
          ok = 0;
      hit |= ok;
    end
    chk("pixel stream", 1, hit);
    chk("pixel idle", 0, got[got.size()-1]);
    $display("test video mode %h done", md);
  endtask : vrun

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] lat;
    logic [1:0]  a;
    logic [7:0]  h;
    logic        ch;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 9; i++)
      rreg(i, (i == 8) ? 8'hFF : 8'h00);
    io(1'b0, 1'b0, 8'h00);
    chk("pointer", 8'h08, io_rdata_o);
    $display("test reset values done");
    for (int t = 0; t < 60; t++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        rv[i] = 8'(rnd()) & MSK[i];
        if (t == 0 && i == 8)
          rv[i] = 8'h00;
        if (t == 1 && i == 3)
          rv[i] = 8'h07;
        if (t == 2 || t == 3)
          rv[i] = CRN[t-2][i];
        io(1'b1, 1'b0, 8'(i));
        io(1'b1, 1'b1, rv[i]);
      end
      for (int i = 0; i < 9; i++)
        rreg(i, rv[i]);
      a = 2'(rnd());
      h = 8'(rnd());
      ch = (seed[2:0] == 3'h0) && (t > 3);
      seq_chain_i <= ch;
      lat = mdl.mem_q[a];
      mem(1'b0, a, 8'h00);
      chk("read valid", 1, mem_rvalid_o);
      chk("read data", exp_rd(lat, a, ch), mem_rdata_o);
      mem(1'b1, a, h);
      chk("write valid", 1, map_wvalid_o);
      chk("write data", exp_wr(h, lat), map_wdata_o);
      chk("write enables", rv[5][4] ? (a[0] ? 4'hA : 4'h5) : 4'hF, map_we_o);
    end
    $display("test datapath done");
    seq_chain_i <= 1'b0;
    vrun(8'h00, 16);
    vrun(8'h20, 2);
    vrun(8'h40, 2);
    finish_test();
  end
endmodule : tb
